// ---- status_map.vh ----
`ifndef STATUS_MAP_VH
`define STATUS_MAP_VH
// set selectors
`define SET_DEV        2'h0
`define SET_OPER       2'h1
`define SET_CALIB      2'h2
`define SET_LOWLIM     2'h3
// command codes
`define CMD_COND       3'h0
`define CMD_EVENT      3'h1
`define CMD_ENAB_WR    3'h2
`define CMD_ENAB_RD    3'h3
`define CMD_NTR_WR     3'h4
`define CMD_NTR_RD     3'h5
`define CMD_PTR_WR     3'h6
`define CMD_PTR_RD     3'h7
// bit positions
`define DEV_NVM_BIT    3
`define OPER_CAL_BIT   0
`define OPER_MEAS_BIT  4
`define OPER_TRIG_BIT  5
`define OPER_SENS_BIT  10
`define OPER_LLF_BIT   11
`define OPER_ULF_BIT   12
`define CHILD_BIT      1
// used-bit masks per set
`define DEV_MASK       16'h0008
`define OPER_MASK      16'h1C31
`define CHILD_MASK     16'h0002
// preset values
`define PRE_ENAB_ONES  16'h7FFF
`define PRE_ENAB_ZERO  16'h0000
`define PRE_PTR        16'h7FFF
`define PRE_NTR        16'h0000
`endif

// ---- status_set.v ----
`timescale 1ns/100ps
`default_nettype none
`include "status_map.vh"
module status_set #(
  parameter [15:0] USEDMASK  = 16'h0000,
  parameter [15:0] PREENABLE = 16'h7FFF
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [15:0] condIn,
  input  wire        preset,
  input  wire        enableWr,
  input  wire        ntrWr,
  input  wire        ptrWr,
  input  wire        eventClr,
  input  wire [15:0] wrData,
  output wire [15:0] condOut,
  output wire [15:0] eventOut,
  output wire [15:0] enableOut,
  output wire [15:0] ntrOut,
  output wire [15:0] ptrOut,
  output wire        summary
);
  reg  [15:0] cond_r;
  reg  [15:0] event_r;
  reg  [15:0] enable_r;
  reg  [15:0] ntr_r;
  reg  [15:0] ptr_r;
  wire [15:0] condNow;
  wire [15:0] hits;

  assign condNow = condIn & USEDMASK & 16'h7FFF;
  // rising edge through ptr, falling through ntr
  assign hits = ((condNow & ~cond_r) & ptr_r) |
                ((~condNow & cond_r) & ntr_r);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cond_r   <= 16'h0000;
      event_r  <= 16'h0000;
      enable_r <= PREENABLE;
      ntr_r    <= `PRE_NTR;
      ptr_r    <= `PRE_PTR;
    end else begin
      cond_r <= condNow;
      // a new hit survives a read-clear in the same cycle
      if (eventClr) begin
        event_r <= hits;
      end else begin
        event_r <= event_r | hits;
      end
      if (preset) begin
        enable_r <= PREENABLE;
        ntr_r    <= `PRE_NTR;
        ptr_r    <= `PRE_PTR;
      end else begin
        if (enableWr) begin
          enable_r <= {1'b0, wrData[14:0]};
        end
        if (ntrWr) begin
          ntr_r <= {1'b0, wrData[14:0]};
        end
        if (ptrWr) begin
          ptr_r <= {1'b0, wrData[14:0]};
        end
      end
    end
  end

  assign condOut   = cond_r;
  assign eventOut  = event_r & USEDMASK;
  assign enableOut = enable_r;
  assign ntrOut    = ntr_r;
  assign ptrOut    = ptr_r;
  assign summary   = |(event_r & enable_r & USEDMASK);
endmodule // status_set
`default_nettype wire

// ---- status_register_sets.v ----
// Operation
// - condition query returns bits, no change
// - event query returns bits, then clears
// - enable write keeps low 15 bits
// - enable query returns stored mask
// - negative filter write keeps 15 bits
// - negative filter query returns contents
// - positive filter write keeps 15 bits
// - positive filter query returns contents
// - device bit 3 shows memory failure
// - operation bits 0, 4, 5 summaries
// - operation bits 10, 11, 12 summaries
// - unused bits read zero in condition and event queries; bit 15 always reads zero
// - calibrating bit sets at run start
// - calibrating bit clears at run end
// - lower limit bit sets on failure
// - clears on enabled passing measurement only
// - preset loads enables and filters
`timescale 1ns/100ps
`default_nettype none
`include "status_map.vh"
module status_register_sets (
  input  wire        clk,
  input  wire        nrst,
  // command port, one request per cycle
  input  wire        cmdValid,
  input  wire [1:0]  cmdSet,
  input  wire [2:0]  cmdOp,
  input  wire [15:0] cmdData,
  input  wire        presetReq,
  // device state inputs
  input  wire        nvmFailed,
  input  wire        calStart,
  input  wire        calDone,
  input  wire        measuringSummary,
  input  wire        triggerWaitSummary,
  input  wire        senseSummary,
  input  wire        upperLimitFailSummary,
  input  wire        limitFailed,
  input  wire        measDone,
  input  wire        limitTestEnabled,
  // answer port
  output reg         rspValid,
  output reg  [15:0] rspData
);
  ////////////////////////////////////////////////////////////////////////
  reg         calibrating_r;
  reg         lowerLimitFail_r;
  wire [15:0] cond0;
  wire [15:0] cond1;
  wire [15:0] cond2;
  wire [15:0] cond3;
  wire [3:0]  summ;
  wire [15:0] condQ [0:3];
  wire [15:0] evtQ  [0:3];
  wire [15:0] enQ   [0:3];
  wire [15:0] ntrQ  [0:3];
  wire [15:0] ptrQ  [0:3];
  wire [3:0]  selHit;
  wire        isEnWr;
  wire        isNtrWr;
  wire        isPtrWr;
  wire        isEvt;
  reg  [15:0] rspNxt;

  // start wins over done if both in one cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      calibrating_r    <= 1'b0;
      lowerLimitFail_r <= 1'b0;
    end else begin
      if (calStart) begin
        calibrating_r <= 1'b1;
      end else if (calDone) begin
        calibrating_r <= 1'b0;
      end
      if (limitFailed) begin
        lowerLimitFail_r <= 1'b1;
      end else if (measDone && limitTestEnabled) begin
        lowerLimitFail_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign cond0 = {12'h000, nvmFailed, 3'h0};
  assign cond2 = {14'h0000, calibrating_r, 1'b0};
  assign cond3 = {14'h0000, lowerLimitFail_r, 1'b0};
  // child summaries feed the parent one cycle late
  assign cond1 = {3'h0, upperLimitFailSummary, summ[`SET_LOWLIM],
                  senseSummary, 4'h0, triggerWaitSummary,
                  measuringSummary, 3'h0, summ[`SET_CALIB]};

  assign isEnWr  = cmdValid && (cmdOp == `CMD_ENAB_WR);
  assign isNtrWr = cmdValid && (cmdOp == `CMD_NTR_WR);
  assign isPtrWr = cmdValid && (cmdOp == `CMD_PTR_WR);
  assign isEvt   = cmdValid && (cmdOp == `CMD_EVENT);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gSet
      assign selHit[g] = (cmdSet == g);
      status_set #(
        .USEDMASK  (g == 0 ? `DEV_MASK :
                    (g == 1 ? `OPER_MASK : `CHILD_MASK)),
        .PREENABLE (g == 1 ? `PRE_ENAB_ZERO : `PRE_ENAB_ONES)
      ) uSet (
        .clk       (clk),
        .nrst      (nrst),
        .condIn    (g == 0 ? cond0 : (g == 1 ? cond1 :
                    (g == 2 ? cond2 : cond3))),
        .preset    (presetReq),
        .enableWr  (isEnWr && selHit[g]),
        .ntrWr     (isNtrWr && selHit[g]),
        .ptrWr     (isPtrWr && selHit[g]),
        .eventClr  (isEvt && selHit[g]),
        .wrData    (cmdData),
        .condOut   (condQ[g]),
        .eventOut  (evtQ[g]),
        .enableOut (enQ[g]),
        .ntrOut    (ntrQ[g]),
        .ptrOut    (ptrQ[g]),
        .summary   (summ[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    case (cmdOp)
      `CMD_COND:    rspNxt = condQ[cmdSet];
      `CMD_EVENT:   rspNxt = evtQ[cmdSet];
      `CMD_ENAB_RD: rspNxt = enQ[cmdSet];
      `CMD_NTR_RD:  rspNxt = ntrQ[cmdSet];
      `CMD_PTR_RD:  rspNxt = ptrQ[cmdSet];
      default:      rspNxt = 16'h0000;
    endcase
  end

  // writes answer too, with zero, so every command is acknowledged
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rspValid <= 1'b0;
      rspData  <= 16'h0000;
    end else begin
      rspValid <= cmdValid;
      if (cmdValid) begin
        rspData <= rspNxt & 16'h7FFF;
      end
    end
  end
endmodule // status_register_sets
`default_nettype wire

// ---- status_register_sets_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module status_register_sets_checker (
  input wire        clk, nrst, cmdValid, nvmFailed, rspValid,
  input wire [1:0]  cmdSet,
  input wire [2:0]  cmdOp,
  input wire [15:0] rspData
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rd = cmdValid && cmdOp < 3'h2;
  wire devCond = rd && cmdSet == 2'h0 && cmdOp == 3'h0;
  AST_ANSWER: assert property (cmdValid |=> rspValid) else $error("no reply");
  AST_NO_SPUR: assert property (!cmdValid |=> !rspValid) else $error("stray");
  AST_BIT15: assert property (rspValid |-> !rspData[15])
    else $error("bit 15 set");
  AST_WR_ZERO: assert property (cmdValid && cmdOp inside {3'h2, 3'h4, 3'h6}
    |=> rspData == 16'h0000) else $error("write answer");
  AST_DEV_USED: assert property (rd && cmdSet == 2'h0 |=>
    (rspData & 16'hFFF7) == 16'h0000) else $error("device bits");
  AST_OPER_USED: assert property (rd && cmdSet == 2'h1 |=>
    (rspData & 16'hE3CE) == 16'h0000) else $error("operation bits");
  AST_CHILD_USED: assert property (rd && cmdSet[1] |=>
    (rspData & 16'hFFFD) == 16'h0000) else $error("child bits");
  // condition flop lags its input, so the level must stand a while
  AST_NVM_SET: assert property (nvmFailed [*3] ##0 devCond |=>
    rspData[3]) else $error("memory flag");
  cover property (devCond);
  cover property (cmdValid && cmdOp == 3'h2);
  cover property (rspValid && rspData != 16'h0000);
endmodule // status_register_sets_checker
`default_nettype wire

// ---- status_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module status_host_model (
  input  wire         clk, rspValid,
  input  wire  [15:0] rspData,
  output logic        cmdValid = 1'b0,
  output logic [1:0]  cmdSet = 2'h0,
  output logic [2:0]  cmdOp = 3'h0,
  output logic [15:0] cmdData = 16'h0000
);
  // command taken at the first edge, answer read at the very next one,
  // before that edge's own update replaces it
  task automatic xfer(input logic [1:0] s, input logic [2:0] o,
    input logic [15:0] d, output logic [15:0] r);
    {cmdValid, cmdSet, cmdOp, cmdData} <= {1'b1, s, o, d};
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdData <= ~d;
    @(posedge clk);
    r = rspValid ? rspData : 16'hDEAD;
  endtask
endmodule // status_host_model
`default_nettype wire

// ---- status_register_sets_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module status_register_sets_tb;
  localparam logic [15:0] zero = 16'h0000;
  logic clk = 1'b0, nrst = 1'b0, presetReq = 1'b0, nvmFailed = 1'b0;
  logic calStart = 1'b0, calDone = 1'b0, limitFailed = 1'b0;
  logic measDone = 1'b0, limitTestEnabled = 1'b0, measuringSummary = 1'b0;
  logic triggerWaitSummary = 1'b0, senseSummary = 1'b0;
  logic upperLimitFailSummary = 1'b0, cmdValid, rspValid;
  logic [1:0]  cmdSet;
  logic [2:0]  cmdOp;
  logic [15:0] cmdData, rspData;
  int fails = 0, checks_done = 0;
  always #25 clk = ~clk;
  status_register_sets dut_u (.clk, .nrst, .cmdValid, .cmdSet, .cmdOp,
    .cmdData, .presetReq, .nvmFailed, .calStart, .calDone, .measuringSummary,
    .triggerWaitSummary, .senseSummary, .upperLimitFailSummary,
    .limitFailed, .measDone, .limitTestEnabled, .rspValid, .rspData);
  status_host_model host_u (.clk, .rspValid, .rspData, .cmdValid, .cmdSet,
    .cmdOp, .cmdData);
  task automatic q(input logic [1:0] s, input logic [2:0] o,
    input logic [15:0] d, input logic [15:0] e);
    logic [15:0] r;
    host_u.xfer(s, o, d, r);
    checks_done++;
    if (r !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, r, e);
    end
  endtask
  task automatic filters;
    for (int s = 0; s < 4; s++) begin
      q(s[1:0], 3'h2, 16'hA5A5, zero);
      q(s[1:0], 3'h4, 16'hC3C3, zero);
      q(s[1:0], 3'h6, 16'h8001, zero);
      q(s[1:0], 3'h3, zero, 16'h25A5);
      q(s[1:0], 3'h5, zero, 16'h43C3);
      q(s[1:0], 3'h7, zero, 16'h0001);
    end
    presetReq <= 1'b1;
    @(posedge clk);
    presetReq <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      q(s[1:0], 3'h3, zero, s == 1 ? zero : 16'h7FFF);
      q(s[1:0], 3'h5, zero, zero);
      q(s[1:0], 3'h7, zero, 16'h7FFF);
    end
    $display("filters done");
  endtask
  task automatic events;
    nvmFailed <= 1'b1;
    repeat (4) @(posedge clk);
    q(2'h0, 3'h0, zero, 16'h0008);
    q(2'h0, 3'h0, zero, 16'h0008);
    q(2'h0, 3'h1, zero, 16'h0008);
    q(2'h0, 3'h1, zero, zero);
    q(2'h0, 3'h4, 16'h0008, zero);
    {nvmFailed, calStart, measuringSummary, triggerWaitSummary} <= 4'h7;
    {senseSummary, upperLimitFailSummary} <= 2'h3;
    @(posedge clk);
    calStart <= 1'b0;
    repeat (5) @(posedge clk);
    q(2'h0, 3'h0, zero, zero);
    q(2'h0, 3'h1, zero, 16'h0008);
    q(2'h2, 3'h0, zero, 16'h0002);
    q(2'h1, 3'h0, zero, 16'h1431);
    {calDone, limitFailed} <= 2'h3;
    @(posedge clk);
    {calDone, limitFailed, measuringSummary, triggerWaitSummary} <= 4'h0;
    {senseSummary, upperLimitFailSummary} <= 2'h0;
    q(2'h2, 3'h1, zero, 16'h0002);
    q(2'h2, 3'h0, zero, zero);
    q(2'h3, 3'h0, zero, 16'h0002);
    q(2'h1, 3'h0, zero, 16'h0800);
    q(2'h3, 3'h2, zero, zero);
    q(2'h1, 3'h0, zero, zero);
    measDone <= 1'b1;
    @(posedge clk);
    {measDone, limitTestEnabled} <= 2'h1;
    q(2'h3, 3'h0, zero, 16'h0002);
    measDone <= 1'b1;
    @(posedge clk);
    measDone <= 1'b0;
    repeat (3) @(posedge clk);
    q(2'h3, 3'h0, zero, zero);
    $display("events done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    filters;
    events;
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    print_verdict;
  end
endmodule // status_register_sets_tb
bind status_register_sets status_register_sets_checker chk_u (.clk(clk),
  .nrst(nrst), .cmdValid(cmdValid), .nvmFailed(nvmFailed),
  .rspValid(rspValid), .cmdSet(cmdSet), .cmdOp(cmdOp), .rspData(rspData));
`default_nettype wire
